// *** sap_signal_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none

module sap_signal_decoder
    import sap_pkg::*;
(
    input wire logic I_CLK_SYS,             // 250 MHz clock
    input wire logic I_RST,                 // sync reset, high
    input wire logic I_STOP_N,              // stop line, low active
    input wire logic I_APPROACH_N,          // approach line, low
    input wire logic I_ADV_APPROACH_N,      // advance approach, low
    input wire logic I_APPROACH_LIGHT_N,    // approach light, low
    input wire logic I_APPROACH_DIV,        // high means diverging
    input wire logic [7:0] I_ADDR,          // register byte address
    input wire logic [31:0] I_WDATA,        // register write data
    input wire logic I_WR,                  // write strobe
    input wire logic I_RD,                  // read strobe
    output logic [31:0] O_RDATA,            // read data, next cycle
    output logic O_IND_STOP,                // Stop indication
    output logic O_IND_APPR_DIV,            // Approach Diverging
    output logic O_IND_APPR,                // Approach indication
    output logic O_IND_ADV,                 // Advance Approach
    output logic O_IND_CLEAR,               // Clear indication
    output logic O_LAMP_ON                  // signal lit, low = dark
);

    // ------------------------------------------------------------
    // shared decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] offs);
        return addr == offs;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sap_occ_if occ ();

    logic [4:0] pins;
    logic [2:0] ctrl_ff;
    logic [4:0] ind_ff;
    logic lamp_ff;
    logic [15:0] changes_ff;
    logic [15:0] stops_ff;
    logic [31:0] rdata_ff;
    logic [4:0] nxt_ind;
    logic nxt_lamp;
    logic [31:0] nxt_rdata;
    logic [4:0] sync_lvl;
    logic ind_change;
    logic stop_entry;
    logic wr_ctrl;
    logic wr_changes;
    logic wr_stops;

    // ------------------------------------------------------------
    // pin synchronisers and priority decoder
    // ------------------------------------------------------------
    always_comb begin
        pins = '0;
        pins[PIN_STOP] = I_STOP_N;
        pins[PIN_APPR] = I_APPROACH_N;
        pins[PIN_ADV] = I_ADV_APPROACH_N;
        pins[PIN_AL] = I_APPROACH_LIGHT_N;
        pins[PIN_DIV] = I_APPROACH_DIV;
    end

    sap_sync u_sync (
        .i_clk (I_CLK_SYS),
        .i_rst (I_RST),
        .i_pins (pins),
        .occ (occ.sync)
    );

    // optional features are steered from the control register
    assign occ.div_en = ctrl_ff[CTRL_DIV_EN];
    assign occ.adv_en = ctrl_ff[CTRL_ADV_EN];
    assign occ.al_en = ctrl_ff[CTRL_AL_EN];

    sap_decode u_decode (
        .occ (occ.dec)
    );

    // ------------------------------------------------------------
    // indication outputs
    // ------------------------------------------------------------
    // one register stage so every pin is driven from a flop; the
    // decode itself is stateless, so a new level shows 3 clocks
    // after it reaches the pin
    assign nxt_ind = occ.ind;
    assign nxt_lamp = |occ.ind;

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ind_ff <= IND_RESET;
            lamp_ff <= 1'b1;
        end else begin
            ind_ff <= nxt_ind;
            lamp_ff <= nxt_lamp;
        end
    end

    assign O_IND_STOP = ind_ff[IND_STOP];
    assign O_IND_APPR_DIV = ind_ff[IND_APPR_DIV];
    assign O_IND_APPR = ind_ff[IND_APPR];
    assign O_IND_ADV = ind_ff[IND_ADV];
    assign O_IND_CLEAR = ind_ff[IND_CLEAR];
    assign O_LAMP_ON = lamp_ff;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign wr_ctrl = I_WR & reg_hit(I_ADDR, REG_CTRL);
    assign wr_changes = I_WR & reg_hit(I_ADDR, REG_CHANGES);
    assign wr_stops = I_WR & reg_hit(I_ADDR, REG_STOPS);

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= I_WDATA[CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // activity counters
    // ------------------------------------------------------------
    // counters saturate rather than wrap, so a busy line never
    // reads as quiet; a write clears, a same-cycle event still
    // counts as one
    assign ind_change = nxt_ind != ind_ff;
    assign stop_entry = nxt_ind[IND_STOP] & ~ind_ff[IND_STOP];

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            changes_ff <= CNT_RESET;
        end else if (wr_changes) begin
            changes_ff <= ind_change ? CNT_ONE : CNT_RESET;
        end else if (ind_change && changes_ff != '1) begin
            changes_ff <= changes_ff + CNT_ONE;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            stops_ff <= CNT_RESET;
        end else if (wr_stops) begin
            stops_ff <= stop_entry ? CNT_ONE : CNT_RESET;
        end else if (stop_entry && stops_ff != '1) begin
            stops_ff <= stops_ff + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        sync_lvl = '0;
        sync_lvl[PIN_STOP] = occ.stop_n;
        sync_lvl[PIN_APPR] = occ.appr_n;
        sync_lvl[PIN_ADV] = occ.adv_n;
        sync_lvl[PIN_AL] = occ.al_n;
        sync_lvl[PIN_DIV] = occ.div;
    end

    // unmapped addresses read zero
    always_comb begin
        nxt_rdata = RDATA_RESET;
        if (reg_hit(I_ADDR, REG_CTRL)) begin
            nxt_rdata[CTRL_W-1:0] = ctrl_ff;
        end else if (reg_hit(I_ADDR, REG_STATUS)) begin
            nxt_rdata[STAT_PINS_LSB +: PIN_W] = sync_lvl;
            nxt_rdata[STAT_IND_LSB +: IND_W] = ind_ff;
            nxt_rdata[STAT_LAMP] = lamp_ff;
        end else if (reg_hit(I_ADDR, REG_CHANGES)) begin
            nxt_rdata[CNT_W-1:0] = changes_ff;
        end else if (reg_hit(I_ADDR, REG_STOPS)) begin
            nxt_rdata[CNT_W-1:0] = stops_ff;
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            rdata_ff <= RDATA_RESET;
        end else if (I_RD) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= RDATA_RESET;
        end
    end

    assign O_RDATA = rdata_ff;

endmodule

`default_nettype wire

// *** sap_pkg.sv ***
`default_nettype none

package sap_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CHANGES = 8'h08;
    localparam logic [7:0] REG_STOPS = 8'h0C;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 3;
    localparam int CTRL_DIV_EN = 0;
    localparam int CTRL_ADV_EN = 1;
    localparam int CTRL_AL_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ------------------------------------------------------------
    // occupancy pin vector, synchroniser reset levels
    // ------------------------------------------------------------
    localparam int PIN_W = 5;
    localparam int PIN_STOP = 0;
    localparam int PIN_APPR = 1;
    localparam int PIN_ADV = 2;
    localparam int PIN_AL = 3;
    localparam int PIN_DIV = 4;
    // active-low lines idle high, diverging line idles low
    localparam logic [4:0] PIN_IDLE = 5'h0F;

    // ------------------------------------------------------------
    // indication one-hot vector
    // ------------------------------------------------------------
    localparam int IND_W = 5;
    localparam int IND_STOP = 0;
    localparam int IND_APPR_DIV = 1;
    localparam int IND_APPR = 2;
    localparam int IND_ADV = 3;
    localparam int IND_CLEAR = 4;
    localparam logic [4:0] IND_RESET = 5'h01;

    // ------------------------------------------------------------
    // status fields and counters
    // ------------------------------------------------------------
    localparam int STAT_PINS_LSB = 0;
    localparam int STAT_IND_LSB = 8;
    localparam int STAT_LAMP = 16;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// *** sap_occ_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface sap_occ_if;
    logic stop_n;
    logic appr_n;
    logic adv_n;
    logic al_n;
    logic div;
    logic div_en;
    logic adv_en;
    logic al_en;
    logic [4:0] ind;

    modport sync (output stop_n, appr_n, adv_n, al_n, div);
    modport dec (input stop_n, appr_n, adv_n, al_n, div,
                 input div_en, adv_en, al_en, output ind);
    modport top (input stop_n, appr_n, adv_n, al_n, div, ind,
                 output div_en, adv_en, al_en);
endinterface

`default_nettype wire

// *** sap_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module sap_sync
    import sap_pkg::*;
(
    input wire logic i_clk,             // system clock
    input wire logic i_rst,             // sync reset, high
    input wire logic [4:0] i_pins,      // raw occupancy pins
    sap_occ_if.sync occ                 // synchronised levels
);

    logic [4:0] meta_ff;
    logic [4:0] sync_ff;

    // ------------------------------------------------------------
    // two-stage synchronisers
    // ------------------------------------------------------------
    // reset to idle levels so nothing looks occupied at start
    genvar g;
    generate
        for (g = 0; g < PIN_W; g = g + 1) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    meta_ff[g] <= PIN_IDLE[g];
                    sync_ff[g] <= PIN_IDLE[g];
                end else begin
                    meta_ff[g] <= i_pins[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign occ.stop_n = sync_ff[PIN_STOP];
    assign occ.appr_n = sync_ff[PIN_APPR];
    assign occ.adv_n = sync_ff[PIN_ADV];
    assign occ.al_n = sync_ff[PIN_AL];
    assign occ.div = sync_ff[PIN_DIV];

endmodule

`default_nettype wire

// *** sap_decode.sv ***
`timescale 1ns/100ps
`default_nettype none

module sap_decode
    import sap_pkg::*;
(
    sap_occ_if.dec occ                  // levels in, one-hot out
);

    // ------------------------------------------------------------
    // fixed-priority decode, most restrictive first
    // ------------------------------------------------------------
    function automatic logic [4:0] decode_ind(
        input logic stop_n, input logic appr_n, input logic adv_n,
        input logic al_n, input logic div,
        input logic div_en, input logic adv_en, input logic al_en);
        logic stop_a;
        logic appr_a;
        logic adv_a;
        logic al_a;
        logic div_a;
        logic [4:0] ind;
        // disabled inputs are forced idle so they cannot steer
        stop_a = ~stop_n;
        appr_a = ~appr_n;
        adv_a = adv_en & ~adv_n;
        al_a = al_en & ~al_n;
        div_a = div_en & div;
        ind = '0;
        if (stop_a) begin
            ind[IND_STOP] = 1'b1;
        end else if (appr_a && div_a) begin
            ind[IND_APPR_DIV] = 1'b1;
        end else if (appr_a) begin
            ind[IND_APPR] = 1'b1;
        end else if (adv_a) begin
            ind[IND_ADV] = 1'b1;
        end else if (al_a || !al_en) begin
            ind[IND_CLEAR] = 1'b1;
        end
        // else dark: every bit stays low
        return ind;
    endfunction

    // no state here: output follows the levels directly
    always_comb begin
        occ.ind = decode_ind(occ.stop_n, occ.appr_n, occ.adv_n,
                             occ.al_n, occ.div, occ.div_en,
                             occ.adv_en, occ.al_en);
    end

endmodule

`default_nettype wire

// *** sap_signal_decoder_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module sap_chk
    import sap_pkg::*;
(
    input wire logic I_CLK_SYS,          // clock
    input wire logic I_RST,              // reset
    input wire logic I_STOP_N,           // stop line
    input wire logic I_APPROACH_N,       // approach line
    input wire logic I_ADV_APPROACH_N,   // advance line
    input wire logic I_APPROACH_LIGHT_N, // light line
    input wire logic I_APPROACH_DIV,     // diverging line
    input wire logic [7:0] I_ADDR,       // address
    input wire logic [31:0] I_WDATA,     // write data
    input wire logic I_WR,               // write strobe
    input wire logic I_RD,               // read strobe
    input wire logic [31:0] O_RDATA,     // read data
    input wire logic O_IND_STOP,         // stop
    input wire logic O_IND_APPR_DIV,     // approach diverging
    input wire logic O_IND_APPR,         // approach
    input wire logic O_IND_ADV,          // advance approach
    input wire logic O_IND_CLEAR,        // clear
    input wire logic O_LAMP_ON           // lamp lit
);
    logic [2:0] ctrl_ff;
    logic [2:0] c;
    logic [2:0] age_ff;
    logic [4:0] d1;
    logic [4:0] d2;
    logic [4:0] p;
    logic [4:0] ind;
    logic ok;
    assign ind = {O_IND_CLEAR, O_IND_ADV, O_IND_APPR, O_IND_APPR_DIV,
                  O_IND_STOP};
    // pins are judged only once the three-edge pipe holds fresh data
    assign ok = age_ff == 3'h4;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ctrl_ff <= CTRL_RESET;
        end else if (I_WR && I_ADDR == REG_CTRL) begin
            ctrl_ff <= I_WDATA[2:0];
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        age_ff <= I_RST ? 3'h0 : (ok ? age_ff : age_ff + 3'h1);
    end
    always_ff @(posedge I_CLK_SYS) begin
        d1 <= {I_APPROACH_DIV, I_APPROACH_LIGHT_N, I_ADV_APPROACH_N,
               I_APPROACH_N, I_STOP_N};
        d2 <= d1;
        p <= d2;
        c <= ctrl_ff;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    sequence s_rd_ctrl;
        I_RD && I_ADDR == REG_CTRL;
    endsequence
    a_stop_first: assert property (ok && !p[0] |-> ind == 5'h01)
        else $error("stop line not first");
    a_appr_normal: assert property (ok && p[0] && !p[1]
        && !(p[4] && c[0]) |-> ind == 5'h04)
        else $error("approach aspect wrong");
    a_appr_div: assert property (ok && p[0] && !p[1]
        && p[4] && c[0] |-> ind == 5'h02)
        else $error("diverging aspect wrong");
    a_adv_aspect: assert property (ok && p[1:0] == 2'h3
        && !p[2] && c[1] |-> ind == 5'h08)
        else $error("advance aspect wrong");
    a_clear_lit: assert property (ok && p[1:0] == 2'h3
        && (p[2] || !c[1]) && !p[3] |-> ind == 5'h10)
        else $error("clear aspect wrong");
    a_dark_idle: assert property (ok && p[1:0] == 2'h3
        && (p[2] || !c[1]) && p[3] && c[2] |-> ind == 5'h00 && !O_LAMP_ON)
        else $error("signal not dark");
    a_clear_idle: assert property (ok && p[1:0] == 2'h3
        && (p[2] || !c[1]) && p[3] && !c[2] |-> ind == 5'h10)
        else $error("idle not clear");
    a_one_hot: assert property ($onehot0(ind)
        && O_LAMP_ON == (ind != 5'h00))
        else $error("indication not one-hot");
    a_ctrl_read: assert property (s_rd_ctrl |=> O_RDATA == {29'h0, c})
        else $error("control readback wrong");
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero");
endmodule

bind sap_signal_decoder sap_chk i_sap_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_STOP_N(I_STOP_N),
    .I_APPROACH_N(I_APPROACH_N), .I_ADV_APPROACH_N(I_ADV_APPROACH_N),
    .I_APPROACH_LIGHT_N(I_APPROACH_LIGHT_N),
    .I_APPROACH_DIV(I_APPROACH_DIV), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IND_STOP(O_IND_STOP),
    .O_IND_APPR_DIV(O_IND_APPR_DIV), .O_IND_APPR(O_IND_APPR),
    .O_IND_ADV(O_IND_ADV), .O_IND_CLEAR(O_IND_CLEAR),
    .O_LAMP_ON(O_LAMP_ON));

`default_nettype wire

// *** sap_occ_bus.sv ***
`timescale 1ns/100ps
`default_nettype none

module sap_occ_bus (
    input wire logic i_stop_occ,  // next block occupied
    input wire logic i_appr_occ,  // block after that occupied
    input wire logic i_adv_occ,   // third block occupied
    input wire logic i_local_occ, // block this signal faces
    input wire logic i_div_route, // turnout contact diverging
    output logic o_stop_n,        // stop wire
    output logic o_appr_n,        // approach wire
    output logic o_adv_n,         // advance wire
    output logic o_al_n,          // approach light wire
    output logic o_div            // diverging wire
);
    // detectors only pull low; the pull-up holds an idle wire high
    assign o_stop_n = !i_stop_occ;
    assign o_appr_n = !i_appr_occ;
    assign o_adv_n = !i_adv_occ;
    // light wire is the local wire of the block facing this signal
    assign o_al_n = !i_local_occ;
    // open contact leaves the pull-down: normal route
    assign o_div = i_div_route;
endmodule

`default_nettype wire

// *** sap_signal_decoder_test.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("ERROR %s exp %h got %h", nm, e, g); \
    end \
end

module sap_signal_decoder_test;
    import sap_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] occ = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] pin;
    logic [4:0] ind;
    logic lamp;
    int err_count = 0;
    int tests_run = 0;

    always #2 clk = ~clk;

    sap_occ_bus i_sap_occ_bus (.i_stop_occ(occ[0]), .i_appr_occ(occ[1]),
        .i_adv_occ(occ[2]), .i_local_occ(occ[3]), .i_div_route(occ[4]),
        .o_stop_n(pin[0]), .o_appr_n(pin[1]), .o_adv_n(pin[2]),
        .o_al_n(pin[3]), .o_div(pin[4]));
    sap_signal_decoder i_sap_signal_decoder (.I_CLK_SYS(clk), .I_RST(rst),
        .I_STOP_N(pin[0]), .I_APPROACH_N(pin[1]), .I_ADV_APPROACH_N(pin[2]),
        .I_APPROACH_LIGHT_N(pin[3]), .I_APPROACH_DIV(pin[4]), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_IND_STOP(ind[0]), .O_IND_APPR_DIV(ind[1]), .O_IND_APPR(ind[2]),
        .O_IND_ADV(ind[3]), .O_IND_CLEAR(ind[4]), .O_LAMP_ON(lamp));

    // ------------------------------------------------------------
    // bus and occupancy tasks
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    // pin levels take a fixed three edges to reach the lamps
    task automatic drive(input logic [4:0] p);
        @(posedge clk);
        occ <= {p[4], ~p[3:0]};
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [4:0] exp_ind(input logic [2:0] c,
                                           input logic [4:0] p);
        if (!p[0]) return 5'h01;
        if (!p[1]) return (p[4] && c[0]) ? 5'h02 : 5'h04;
        if (!p[2] && c[1]) return 5'h08;
        if (c[2] && p[3]) return 5'h00;
        return 5'h10;
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial begin
        logic [4:0] e;
        occ <= 5'h00;
        repeat (16) @(posedge clk);
        #1;
        `CHK("reset ind", 5'h01, ind)
        `CHK("reset lamp", 1'b1, lamp)
        @(posedge clk);
        rst <= 1'b0;
        rd_reg("ctrl reset", REG_CTRL, 32'h0000_0000);
        wr_reg(8'h10, 32'h0000_0007);
        rd_reg("unmapped", 8'h10, 32'h0000_0000);
        rd_reg("ctrl kept", REG_CTRL, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            wr_reg(REG_CTRL, 32'(c));
            rd_reg("ctrl", REG_CTRL, 32'(c));
            for (int p = 0; p < 32; p++) begin
                drive(5'(p));
                e = exp_ind(3'(c), 5'(p));
                `CHK("indication", e, ind)
                `CHK("lamp", |e, lamp)
                rd_reg("status", REG_STATUS,
                       {15'h0, |e, 3'h0, e, 3'h0, 5'(p)});
            end
        end
        wr_reg(REG_CTRL, 32'h0000_0000);
        drive(5'h0F);
        wr_reg(REG_CHANGES, 32'h0000_0000);
        wr_reg(REG_STOPS, 32'h0000_0000);
        drive(5'h0E);
        `CHK("stop", 5'h01, ind)
        drive(5'h0F);
        `CHK("back to clear", 5'h10, ind)
        rd_reg("changes", REG_CHANGES, 32'h0000_0002);
        rd_reg("stops", REG_STOPS, 32'h0000_0001);
        wr_reg(REG_CTRL, 32'h0000_0004);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("second reset", 5'h01, ind)
        @(posedge clk);
        rst <= 1'b0;
        rd_reg("ctrl again", REG_CTRL, 32'h0000_0000);
        test_done();
    end
endmodule

`default_nettype wire
